// File: pkt_buf_cfg.svh
// Purpose: constants shared by both ends of the packet buffer
// Assumes: 16-bit packet words, word addresses
// Notes: how it works
// How it works
// RULE1 - Status word, count word, data, 16-bit words
// RULE2 - Data starts at byte 4, max 2043
// RULE3 - Count over two equals total word count
// RULE4 - Receive count even, uneven flag marks last
// RULE5 - Transmit count bit 0 read as zero
// RULE6 - Transmit bytes sent exactly as written
// RULE7 - Length/type field passed as plain data
// RULE8 - Control byte in high byte, last word
// RULE9 - Host control byte: uneven b5, append b4
// RULE10 - Uneven flag decides if last byte sent
// RULE11 - Append flag counts only under suppression
// RULE12 - Receive control byte uneven flag set
// RULE13 - Receive status word stored, no register
// RULE14 - Device writes rx packet, tx status
// RULE15 - Status flags: align, bcast, fcs, odd, group
// RULE16 - Oversize flag above 1518 cable bytes
// RULE17 - Undersize flag below 64 cable bytes
// RULE18 - Hash is top six checksum bits
// RULE19 - Hash 5:3 picks byte, 2:0 bit
// RULE20 - Hash hit multicast always passes filter
// RULE21 - Device stores every received byte; the code stores only the first 2043 data bytes
// RULE22 - Hash in bits 5:0, flags upper byte
// RULE23 - Status flags cleared per new frame
`ifndef PKT_BUF_CFG_SVH
`define PKT_BUF_CFG_SVH
`define PKT_AW          12
`define PKT_TX_BASE     12'h000
`define PKT_RX_BASE     12'h800
`define PKT_W_STATUS    12'h000
`define PKT_W_COUNT     12'h001
`define PKT_W_DATA      12'h002
`define PKT_DATA_MAX    12'd2043
`define PKT_OVERHEAD    12'd6
`define PKT_MIN_CABLE   12'd64
`define PKT_MAX_CABLE   12'd1518
`define PKT_CTL_UNEVEN  5
`define PKT_CTL_APPEND  4
`define PKT_ST_ALIGN    15
`define PKT_ST_BCAST    14
`define PKT_ST_FCS      13
`define PKT_ST_UNEVEN   12
`define PKT_ST_OVER     11
`define PKT_ST_UNDER    10
`define PKT_ST_GROUP    9
`define PKT_REG_PTR     8'h00
`define PKT_REG_DATA    8'h04
`define PKT_REG_SEAL    8'h08
`endif

// File: pkt_buf_pkg.sv
// Purpose: state types of both ends
// Assumes: one-hot codes
// Notes: none
package pkt_buf_pkg;
  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_CNT  = 5'h02,
    T_CTL  = 5'h04,
    T_LOAD = 5'h08,
    T_SEND = 5'h10
  } tx_state_t;
  typedef enum logic [3:0] {
    R_DATA = 4'h1,
    R_CTL  = 4'h2,
    R_CNT  = 4'h4,
    R_STAT = 4'h8
  } rx_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAIT = 3'h2,
    H_DONE = 3'h4
  } host_state_t;
endpackage

// File: pkt_if.sv
// Purpose: word port from host end into the device packet memory
// Assumes: host holds req until ack
// Notes: ack is one cycle, rdata valid with it
`timescale 1ns/1ns
`default_nettype none
`include "pkt_buf_cfg.svh"
interface pkt_if;
  logic                  req;
  logic                  we;
  logic [`PKT_AW-1:0]    addr;
  logic [15:0]           wdata;
  logic [15:0]           rdata;
  logic                  ack;
  modport dev  (input req, we, addr, wdata, output rdata, ack);
  modport host (output req, we, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

// File: pkt_buf_dev.sv
// Purpose: packet memory with transmit reader and receive writer
// Assumes: rx stream has no back-pressure, one byte per valid
// Notes: rx bytes include the checksum, so counts are cable lengths
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pkt_buf_cfg.svh"
module pkt_buf_dev #(
  parameter int DEPTH = 4096
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Host word port
  pkt_if.dev               hif,
  // Control
  input  wire logic        suppress_fcs_ctl,
  input  wire logic [63:0] mcast_table,
  input  wire logic        rx_filter_pass,
  // Transmit stream
  input  wire logic        tx_go,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic             tx_fcs_append,
  input  wire logic        tx_done,
  input  wire logic [15:0] tx_status,
  // Receive stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_last,
  input  wire logic        rx_align_err,
  input  wire logic        rx_fcs_err,
  input  wire logic [31:0] rx_da_fcs,
  output logic             rx_done,
  output logic             rx_accept
);
  logic [15:0]          mem [0:DEPTH-1];
  logic [15:0]          rd_q;
  logic                 ack_q;
  pkt_buf_pkg::tx_state_t tx_st;
  logic [11:0]          tx_cnt;
  logic [11:0]          tx_n;
  logic [11:0]          tx_i;
  logic                 txs_pend;
  logic [15:0]          txs_word;
  pkt_buf_pkg::rx_state_t rx_st;
  logic [11:0]          rx_n;
  logic [11:0]          rx_len;
  logic [7:0]           rx_lo;
  logic                 f_align;
  logic                 f_fcs;
  logic                 f_bcast;
  logic                 f_grp;
  logic [5:0]           f_hash;

  // Transmit read port, data word fetched one byte ahead
  wire [11:0]           tx_nx = tx_i + 12'd1;
  wire                  tx_rd = (tx_st == pkt_buf_pkg::T_CNT)
                              | (tx_st == pkt_buf_pkg::T_CTL)
                              | (tx_st == pkt_buf_pkg::T_LOAD)
                              | (tx_st == pkt_buf_pkg::T_SEND);
  wire [11:0]           tx_ra =
    (tx_st == pkt_buf_pkg::T_CNT) ? `PKT_TX_BASE + `PKT_W_COUNT :
    (tx_st == pkt_buf_pkg::T_CTL) ?
      `PKT_TX_BASE + {1'b0, rd_q[11:1]} - 12'd1 :
      `PKT_TX_BASE + `PKT_W_DATA + {1'b0, tx_nx[11:1]};
  wire [11:0]           cnt_even = {tx_cnt[11:1], 1'b0}; // [RULE5]
  wire [7:0]            ctl_b = rd_q[15:8];              // [RULE8]
  wire [11:0]           next_tx_n = cnt_even - `PKT_OVERHEAD
                          + {11'h000, ctl_b[`PKT_CTL_UNEVEN]}; // [RULE10] [RULE3]
  wire                  next_append = suppress_fcs_ctl ?
                          ctl_b[`PKT_CTL_APPEND] : 1'b1; // [RULE11]
  wire [7:0]            tx_sel = tx_i[0] ? rd_q[15:8] : rd_q[7:0]; // [RULE6] [RULE7]

  // Receive write port
  wire                  rx_first = rx_valid & (rx_len == 12'h000);
  wire                  rx_take = (rx_st == pkt_buf_pkg::R_DATA) & rx_valid;
  wire                  rx_room = rx_n < `PKT_DATA_MAX; // [RULE2]
  wire [11:0]           rx_words = 12'd3 + {1'b0, rx_n[11:1]};
  wire [11:0]           rx_total = {rx_words[10:0], 1'b0}; // [RULE4] [RULE3]
  wire                  hash_hit = mcast_table[f_hash]; // [RULE19]
  wire [15:0]           rx_stword = {f_align, f_bcast, f_fcs, rx_n[0],
                          rx_len > `PKT_MAX_CABLE,
                          rx_len < `PKT_MIN_CABLE,
                          f_grp & ~f_bcast, 3'b000, f_hash}; // [RULE15] [RULE16] [RULE17] [RULE22]
  logic                 rx_we;
  logic [11:0]          rx_wa;
  logic [15:0]          rx_wd;
  always_comb begin
    rx_we = 1'b0;
    rx_wa = `PKT_RX_BASE + `PKT_W_DATA + {1'b0, rx_n[11:1]};
    rx_wd = {rx_byte, rx_lo};
    case (rx_st)
      pkt_buf_pkg::R_DATA: begin
        rx_we = rx_take & rx_room & rx_n[0]; // [RULE21]
      end
      pkt_buf_pkg::R_CTL: begin
        rx_we = 1'b1;
        rx_wd = rx_n[0] ? {8'h20, rx_lo} : 16'h0000; // [RULE12] [RULE8]
      end
      pkt_buf_pkg::R_CNT: begin
        rx_we = 1'b1;
        rx_wa = `PKT_RX_BASE + `PKT_W_COUNT;
        rx_wd = {4'h0, rx_total};
      end
      pkt_buf_pkg::R_STAT: begin
        rx_we = 1'b1;
        rx_wa = `PKT_RX_BASE + `PKT_W_STATUS;
        rx_wd = rx_stword; // [RULE13] [RULE1]
      end
      default: rx_we = 1'b0;
    endcase
  end

  // Memory arbitration
  wire                  txs_we  = txs_pend & ~rx_we;
  wire                  host_wr = hif.req & hif.we & ~ack_q & ~rx_we
                                & ~txs_pend;
  wire                  host_rd = hif.req & ~hif.we & ~ack_q & ~tx_rd;
  wire [11:0]           rd_a    = tx_rd ? tx_ra : hif.addr;

  assign hif.rdata = rd_q;
  assign hif.ack   = ack_q;

  always_ff @(posedge clk_sys) begin
    rd_q <= mem[rd_a];
    if (rx_we) begin
      mem[rx_wa] <= rx_wd;
    end else if (txs_we) begin
      mem[`PKT_TX_BASE + `PKT_W_STATUS] <= txs_word; // [RULE14]
    end else if (host_wr) begin
      mem[hif.addr] <= hif.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q    <= 1'b0;
      txs_pend <= 1'b0;
      txs_word <= 16'h0000;
    end else begin
      ack_q <= host_wr | host_rd;
      if (tx_done) begin
        txs_pend <= 1'b1;
        txs_word <= tx_status;
      end else if (txs_we) begin
        txs_pend <= 1'b0;
      end
    end
  end

  // Transmit engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st         <= pkt_buf_pkg::T_IDLE;
      tx_cnt        <= 12'h000;
      tx_n          <= 12'h000;
      tx_i          <= 12'h000;
      tx_byte       <= 8'h00;
      tx_valid      <= 1'b0;
      tx_last       <= 1'b0;
      tx_fcs_append <= 1'b0;
    end else begin
      case (tx_st)
        pkt_buf_pkg::T_IDLE: begin
          tx_i <= 12'h000;
          if (tx_go) begin
            tx_st <= pkt_buf_pkg::T_CNT;
          end
        end
        pkt_buf_pkg::T_CNT: begin
          tx_st <= pkt_buf_pkg::T_CTL;
        end
        pkt_buf_pkg::T_CTL: begin
          tx_cnt <= rd_q[11:0];
          tx_st  <= pkt_buf_pkg::T_LOAD;
          tx_i   <= 12'hfff;
        end
        pkt_buf_pkg::T_LOAD: begin
          if (tx_i == 12'hfff) begin
            tx_n          <= next_tx_n;
            tx_fcs_append <= next_append;
            tx_i          <= 12'h000;
            if (next_tx_n == 12'h000 || cnt_even < 12'd8) begin
              tx_st <= pkt_buf_pkg::T_IDLE;
            end
          end else begin
            tx_byte  <= tx_sel;
            tx_valid <= 1'b1;
            tx_last  <= (tx_i == tx_n - 12'd1);
            tx_st    <= pkt_buf_pkg::T_SEND;
          end
        end
        pkt_buf_pkg::T_SEND: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            tx_i     <= tx_i + 12'd1;
            tx_st    <= tx_last ? pkt_buf_pkg::T_IDLE
                                : pkt_buf_pkg::T_LOAD;
          end
        end
        default: tx_st <= pkt_buf_pkg::T_IDLE;
      endcase
    end
  end

  // Receive engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st     <= pkt_buf_pkg::R_DATA;
      rx_n      <= 12'h000;
      rx_len    <= 12'h000;
      rx_lo     <= 8'h00;
      f_align   <= 1'b0;
      f_fcs     <= 1'b0;
      f_bcast   <= 1'b0;
      f_grp     <= 1'b0;
      f_hash    <= 6'h00;
      rx_done   <= 1'b0;
      rx_accept <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_st)
        pkt_buf_pkg::R_DATA: begin
          if (rx_take) begin
            if (rx_first) begin
              f_align <= 1'b0; // [RULE23]
              f_fcs   <= 1'b0;
              f_hash  <= 6'h00;
              f_grp   <= rx_byte[0];
              f_bcast <= (rx_byte == 8'hff);
            end else if (rx_len < 12'd6) begin
              f_bcast <= f_bcast & (rx_byte == 8'hff);
            end
            if (rx_len != 12'hfff) begin
              rx_len <= rx_len + 12'd1;
            end
            if (rx_room) begin
              rx_n <= rx_n + 12'd1;
              if (!rx_n[0]) begin
                rx_lo <= rx_byte;
              end
            end
            if (rx_last) begin
              f_align <= rx_align_err;
              f_fcs   <= rx_fcs_err;
              f_hash  <= rx_da_fcs[31:26]; // [RULE18]
              rx_st   <= pkt_buf_pkg::R_CTL;
            end
          end
        end
        pkt_buf_pkg::R_CTL: rx_st <= pkt_buf_pkg::R_CNT;
        pkt_buf_pkg::R_CNT: rx_st <= pkt_buf_pkg::R_STAT;
        pkt_buf_pkg::R_STAT: begin
          rx_done   <= 1'b1;
          rx_accept <= rx_filter_pass
                     | (f_grp & ~f_bcast & hash_hit); // [RULE20]
          rx_n      <= 12'h000;
          rx_len    <= 12'h000;
          rx_st     <= pkt_buf_pkg::R_DATA;
        end
        default: rx_st <= pkt_buf_pkg::R_DATA;
      endcase
    end
  end
endmodule // pkt_buf_dev
`default_nettype wire

// File: pkt_buf_host.sv
// Purpose: APB slave that loads and reads packet memory words
// Assumes: APB master holds request until pready
// Notes: data accesses and seal writes auto-increment the pointer
`timescale 1ns/1ns
`default_nettype none
`include "pkt_buf_cfg.svh"
module pkt_buf_host (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device word port
  pkt_if.host              hif
);
  pkt_buf_pkg::host_state_t st;
  logic [11:0]          ptr;
  logic                 req_q;
  logic                 we_q;
  logic [15:0]          wd_q;

  wire                  acc     = psel & penable & ~pready;
  wire                  is_ptr  = paddr == `PKT_REG_PTR;
  wire                  is_data = paddr == `PKT_REG_DATA;
  wire                  is_seal = (paddr == `PKT_REG_SEAL) & pwrite;
  wire [15:0]           seal_w  = {2'b00, pwdata[8], pwdata[9], 4'h0,
                                   pwdata[7:0]}; // [RULE9] [RULE8]

  assign hif.req   = req_q;
  assign hif.we    = we_q;
  assign hif.addr  = ptr;
  assign hif.wdata = wd_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st      <= pkt_buf_pkg::H_IDLE;
      ptr     <= 12'h000;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      wd_q    <= 16'h0000;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      case (st)
        pkt_buf_pkg::H_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (acc) begin
            if (is_data || is_seal) begin
              req_q <= 1'b1;
              we_q  <= pwrite;
              wd_q  <= is_seal ? seal_w : pwdata[15:0]; // [RULE1]
              st    <= pkt_buf_pkg::H_WAIT;
            end else begin
              if (is_ptr && pwrite) begin
                ptr <= pwdata[11:0];
              end
              prdata  <= is_ptr ? {20'h00000, ptr} : 32'h0000_0000;
              pslverr <= ~is_ptr;
              pready  <= 1'b1;
              st      <= pkt_buf_pkg::H_DONE;
            end
          end
        end
        pkt_buf_pkg::H_WAIT: begin
          if (hif.ack) begin
            req_q  <= 1'b0;
            prdata <= we_q ? 32'h0000_0000 : {16'h0000, hif.rdata};
            ptr    <= ptr + 12'd1;
            pready <= 1'b1;
            st     <= pkt_buf_pkg::H_DONE;
          end
        end
        pkt_buf_pkg::H_DONE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          st      <= pkt_buf_pkg::H_IDLE;
        end
        default: st <= pkt_buf_pkg::H_IDLE;
      endcase
    end
  end
endmodule // pkt_buf_host
`default_nettype wire

// File: pkt_buf_sva.sv
// Purpose: word port and stream checks
// Assumes: one clock, sync active-high reset
// Notes: instantiated beside the interface
`timescale 1ns/1ns
`default_nettype none
`include "pkt_buf_cfg.svh"
module pkt_buf_sva (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  // Word port
  input wire logic             req,
  input wire logic             we,
  input wire logic [`PKT_AW-1:0] addr,
  input wire logic [15:0]      wdata,
  input wire logic             ack,
  // Streams
  input wire logic [7:0]       tx_byte,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic             tx_last,
  input wire logic             rx_valid,
  input wire logic             rx_last,
  input wire logic             rx_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_rx_end; rx_valid && rx_last; endsequence
  sequence s_tx_end; tx_valid && tx_ready && tx_last; endsequence
  property p_ack_cause; ack |-> $past(req) && !$past(ack); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_ack_one; ack |=> !ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req not held");
  property p_ack_bound; $rose(req) |-> ##[1:60] ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("no ack");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved");
  property p_tx_end; s_tx_end |=> !tx_valid [*4]; endproperty
  a_tx_end: assert property (p_tx_end) else $error("byte after last");
  property p_rx_done_time; s_rx_end |-> ##[3:6] rx_done; endproperty
  a_rx_done_time: assert property (p_rx_done_time) else $error("late rx_done");
  property p_rx_done_one; rx_done |=> !rx_done; endproperty
  a_rx_done_one: assert property (p_rx_done_one) else $error("rx_done long");
endmodule // pkt_buf_sva
`default_nettype wire

// File: tb_packet_buffer_descriptor.sv
// Purpose: APB driven test of both buffer ends
// Assumes: host at APB, device streams driven here
// Notes: tx at word 0x000, rx at word 0x800
`timescale 1ns/1ns
`default_nettype none
`include "pkt_buf_cfg.svh"
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_packet_buffer_descriptor;
  logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, rx_byte = '0, tx_byte;
  logic [31:0] pwdata = '0, prdata, rv, rx_da_fcs = '0;
  logic        pready, pslverr, re, tx_valid, tx_last, tx_fcs_append;
  logic        suppress_fcs_ctl = 0, rx_filter_pass = 0, tx_go = 0;
  logic        tx_ready = 0, tx_done = 0, rx_valid = 0, rx_last = 0;
  logic        rx_align_err = 0, rx_fcs_err = 0, rx_done, rx_accept;
  logic [63:0] mcast_table = 64'h0000_0080_0000_0000;
  logic [15:0] tx_status = '0;
  int          n_errors = 0, comparisons = 0;
  int          fn[4] = '{63, 64, 1519, 65};
  logic [7:0]  fd[4] = '{8'h01, 8'hff, 8'h02, 8'h03};
  logic [31:0] fh[4] = '{32'h9c000000, 32'h9c000000, 32'h0, 32'h04000000};
  pkt_if pkt_if_i ();
  pkt_buf_dev pkt_buf_dev_i (.hif(pkt_if_i), .*);
  pkt_buf_host pkt_buf_host_i (.hif(pkt_if_i), .*);
  pkt_buf_sva pkt_buf_sva_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req(pkt_if_i.req), .we(pkt_if_i.we), .addr(pkt_if_i.addr),
    .wdata(pkt_if_i.wdata), .ack(pkt_if_i.ack), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_done(rx_done));
  always #50 clk_sys = ~clk_sys;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata; re = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [7:0] rb(input int i, input logic [7:0] d0);
    if (i < 6) return (d0 == 8'hff || i == 0) ? d0 : 8'h00;
    return i[7:0] ^ 8'h5a;
  endfunction
  task automatic finish_test;
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #5000000;
    n_errors++;
    finish_test;
  end
  initial begin
    int f, i, j, k, nb;
    logic [15:0] st;
    logic [7:0]  b[5];
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Transmit: uneven, append and suppression combinations
    for (f = 0; f < 3; f++) begin
      for (i = 0; i < 5; i++) b[i] = 8'h10 + 8'(i) + 8'(f * 8);
      suppress_fcs_ctl <= (f != 0);
      apb(1'b1, 8'h00, '0);
      apb(1'b1, 8'h04, 32'hdead);
      apb(1'b1, 8'h04, 32'h000b);
      apb(1'b1, 8'h04, {16'h0, b[1], b[0]});
      apb(1'b1, 8'h04, {16'h0, b[3], b[2]});
      apb(1'b1, 8'h08, {22'h0, f == 1, f != 1, b[4]});
      nb = (f != 1) ? 5 : 4;
      tx_go <= 1'b1;
      @(posedge clk_sys) tx_go <= 1'b0;
      j = 0;
      k = 0;
      while (j < nb && k < 200) begin
        @(posedge clk_sys);
        k++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
          `CHK("tx_byte", b[j], tx_byte)
          `CHK("tx_last", j == nb - 1, tx_last)
          j++;
        end
        tx_ready <= k[1];
      end
      tx_ready <= 1'b0;
      repeat (6) @(posedge clk_sys);
      `CHK("tx_bytes", nb, j)
      `CHK("tx_extra", 1'b0, tx_valid)
      `CHK("tx_fcs_append", f != 2, tx_fcs_append)
      tx_status <= 16'ha5c0 + 16'(f);
      tx_done <= 1'b1;
      @(posedge clk_sys) tx_done <= 1'b0;
      apb(1'b1, 8'h00, '0);
      apb(1'b0, 8'h04, '0);
      `CHK("tx_status", {16'h0, 16'ha5c0 + 16'(f)}, rv)
      apb(1'b0, 8'h0c, '0);
      `CHK("unmapped", 1'b1, re)
      apb(1'b0, 8'h08, '0);
      `CHK("seal_read", 1'b1, re)
      apb(1'b0, 8'h00, '0);
      `CHK("ptr", 32'h1, rv)
    end
    // Receive: multicast hit, broadcast, oversize, multicast miss
    for (f = 0; f < 4; f++) begin
      nb = fn[f];
      rx_filter_pass <= (f == 2);
      for (i = 0; i < nb; i++) begin
        rx_valid <= 1'b1; rx_byte <= rb(i, fd[f]); rx_last <= (i == nb - 1);
        rx_align_err <= (f == 0); rx_fcs_err <= (f == 1); rx_da_fcs <= fh[f];
        @(posedge clk_sys);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      k = 0;
      do begin @(posedge clk_sys); k++; end while (rx_done !== 1'b1 && k < 20);
      `CHK("rx_done", 1'b1, rx_done)
      `CHK("rx_accept", f[0] == 1'b0, rx_accept)
      st = {f == 0, f == 1, f == 1, nb[0], nb > 1518, nb < 64,
            fd[f][0] & (f != 1), 3'b0, fh[f][31:26]};
      apb(1'b1, 8'h00, 32'h800);
      apb(1'b0, 8'h04, '0);
      `CHK("rx_status", {16'h0, st}, rv)
      apb(1'b0, 8'h04, '0);
      `CHK("rx_count", 32'(2 * (3 + nb / 2)), rv)
      for (i = 0; i < nb / 2; i++) begin
        apb(1'b0, 8'h04, '0);
        `CHK("rx_data", {16'h0, rb(2*i+1, fd[f]), rb(2*i, fd[f])}, rv)
      end
      apb(1'b0, 8'h04, '0);
      `CHK("rx_ctl", {16'h0, nb[0] ? {8'h20, rb(nb-1, fd[f])} : 16'h0}, rv)
    end
    finish_test;
  end
endmodule // tb_packet_buffer_descriptor
`default_nettype wire
